// ### rtl/apw_divider.sv
`timescale 1ns/1ps
// Free-running divider giving a one-cycle enable every PERIOD clocks.
module apw_divider #(
    parameter int PERIOD = 10
) (
    input wire logic core_clk,
    input wire logic rstn,
    output logic tick
);
    localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    logic [W-1:0] cnt_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r == W'(PERIOD - 1)) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// ### rtl/apw_err_duty.sv
`timescale 1ns/1ps
// Picks the highest-priority active error and its fixed duty in PWM ticks.
module apw_err_duty #(
    parameter int CODES = 12
) (
    input wire logic [CODES-1:0] err_vec,
    output logic err_any,
    output logic [12:0] err_high_ticks
);
    // Duty = 5% + 5.625% * priority index, in ticks of a 4551-tick period.
    function automatic logic [12:0] duty_of(input int idx);
        int t;
        begin
            t = (apw_pkg::PWM_PERIOD_TICKS * (800 + 900 * idx) + 8000) / 16000;
            duty_of = t[12:0];
        end
    endfunction

    always_comb begin
        err_any = |err_vec;
        err_high_ticks = 13'h0000;
        for (int i = CODES - 1; i >= 0; i--) begin
            if (err_vec[i]) begin
                err_high_ticks = duty_of(i);
            end
        end
    end
endmodule

// ### rtl/apw_pkg.sv
package apw_pkg;

    // System clock and angle/refresh timing.
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ANGLE_UPDATE_PERIOD_NS = 1000;
    localparam int ANGLE_UPDATE_CYCLES = ANGLE_UPDATE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RESPONSE_NS = 10000;
    localparam int RESPONSE_CYCLES = RESPONSE_NS / CLK_PERIOD_NS;
    localparam int ZCD_REFRESH_NS = 32000;
    localparam int ZCD_REFRESH_CYCLES = ZCD_REFRESH_NS / CLK_PERIOD_NS;
    localparam int FIELD_REFRESH_NS = 128000;
    localparam int FIELD_REFRESH_CYCLES = FIELD_REFRESH_NS / CLK_PERIOD_NS;
    localparam int CAPTURE_MAX_NS = 125;
    localparam int CAPTURE_MAX_CYCLES = CAPTURE_MAX_NS / CLK_PERIOD_NS;

    // PWM geometry: one period is 4096 angle steps plus a 5% low and 5% high margin.
    localparam int ANGLE_W = 12;
    localparam int PWM_PERIOD_TICKS = 4551;
    localparam int PWM_CLAMP_LO_TICKS = 228;
    localparam int ERR_CODES = 12;
    localparam logic [12:0] PWM_TICKS_13 = 13'h11c7;

    // Carrier period in clocks is base + ((band unit + fine unit * fine) << band).
    localparam int PWM_BASE_CYCLES = 2800;
    localparam int PWM_BAND_UNIT = 400;
    localparam int PWM_FINE_UNIT = 25;

    // Reset values of the serial and shadow state.
    localparam logic [15:0] SERIAL_OUT_RST = 16'h0000;
    localparam logic [7:0] WRITE_ADR_RST = 8'h00;
    localparam logic [11:0] ZERO_OFFSET_RST = 12'h000;
    localparam logic [3:0] SPI_BITS = 4'hf;

    typedef enum logic [2:0] {
        APW_PWR_LOAD = 3'b001,
        APW_PWR_RUN = 3'b010,
        APW_PWR_IDLE = 3'b100
    } apw_pwr_t;

endpackage

// ### rtl/apw_top.sv
`timescale 1ns/1ps
// Functional notes
// - Duty 5% at zero up to 95%.
// - No constant level during normal angle output.
// - Rising edge fixed; falling edge tracks angle.
// - Errors reach pin only when enabled.
// - Error style 0 tristates the pin.
// - Error style 1 halves frequency, fixed duty.
// - Twelve priority error duties, 5% steps 5.625%.
// - PWM always uses 12-bit angle.
// - 128 carrier steps via band and fine.
// - SPI angle as 12-bit+flags or 15-bit.
// - Angle readout takes exactly sixteen clocks.
// - Angle registers reload every update period.
// - Processed angle is up to about 10 us old.
// - Incremental paths update only on change.
// - Chip-select fall captures data within 125 ns.
// - First shifted bit carries no payload.
// - Zero-crossing register refresh every 32 us.
// - Field-strength register refresh every 128 us.
// - Power-up reloads shadows, resets serial registers.
// - Power-up clears write address pointer.
module apw_top #(
    parameter int RESP_CYCLES = apw_pkg::RESPONSE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [14:0] raw_angle,
    input wire logic [11:0] raw_zcd,
    input wire logic [11:0] raw_field,
    input wire logic [11:0] ee_zero_offset,
    input wire logic [2:0] pwm_band,
    input wire logic [3:0] pwm_freq,
    input wire logic pwm_err_out_en,
    input wire logic pwm_err_style,
    input wire logic [11:0] err_vec,
    input wire logic [3:0] err_flags,
    input wire logic spi_sel_15b,
    input wire logic spi_cs_n,
    input wire logic spi_sclk_fall,
    input wire logic trim_wr,
    input wire logic [11:0] trim_wdata,
    input wire logic [7:0] write_adr_wdata,
    input wire logic write_adr_wr,
    output logic pwm_o,
    output logic pwm_oe,
    output logic spi_miso,
    output logic [14:0] angle_r,
    output logic inc_update,
    output logic [11:0] angle_zcd_r,
    output logic [11:0] field_r,
    output logic [11:0] zero_offset_r,
    output logic [7:0] write_adr_r,
    output logic ready
);
    logic upd_tick;
    logic zcd_tick;
    logic fld_tick;
    logic err_any;
    logic [12:0] err_ticks;
    apw_pkg::apw_pwr_t pwr_r;

    apw_divider #(.PERIOD(apw_pkg::ANGLE_UPDATE_CYCLES)) u_upd (
        .core_clk(core_clk),
        .rstn(rstn),
        .tick(upd_tick)
    );
    apw_divider #(.PERIOD(apw_pkg::ZCD_REFRESH_CYCLES)) u_zcd (
        .core_clk(core_clk),
        .rstn(rstn),
        .tick(zcd_tick)
    );
    apw_divider #(.PERIOD(apw_pkg::FIELD_REFRESH_CYCLES)) u_fld (
        .core_clk(core_clk),
        .rstn(rstn),
        .tick(fld_tick)
    );
    apw_err_duty #(.CODES(apw_pkg::ERR_CODES)) u_err (
        .err_vec(err_vec),
        .err_any(err_any),
        .err_high_ticks(err_ticks)
    );

    // Power-up: one cycle to copy EEPROM shadows, then run.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_r <= apw_pkg::APW_PWR_LOAD;
            ready <= 1'b0;
        end else begin
            case (pwr_r)
                apw_pkg::APW_PWR_LOAD: begin
                    pwr_r <= apw_pkg::APW_PWR_RUN;
                    ready <= 1'b1;
                end
                apw_pkg::APW_PWR_RUN: begin
                    pwr_r <= apw_pkg::APW_PWR_RUN;
                    ready <= 1'b1;
                end
                default: begin
                    pwr_r <= apw_pkg::APW_PWR_LOAD;
                    ready <= 1'b0;
                end
            endcase
        end
    end

    // Shadow trim is loaded from EEPROM at every power-up; runtime writes are volatile.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            zero_offset_r <= apw_pkg::ZERO_OFFSET_RST;
        end else if (pwr_r == apw_pkg::APW_PWR_LOAD) begin
            zero_offset_r <= ee_zero_offset;
        end else if (trim_wr) begin
            zero_offset_r <= trim_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            write_adr_r <= apw_pkg::WRITE_ADR_RST;
        end else if (write_adr_wr && ready) begin
            write_adr_r <= write_adr_wdata;
        end
    end

    // Latency line: the angle is sampled and held, so it ages by up to the front-end pipeline delay.
    // A counter holds one sample in flight, which gives the age without a deep shift array.
    logic [14:0] pipe_r;
    logic [$clog2(RESP_CYCLES+1)-1:0] age_r;
    logic pipe_vld_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pipe_r <= 15'h0000;
            age_r <= '0;
            pipe_vld_r <= 1'b0;
        end else if (!pipe_vld_r) begin
            pipe_r <= raw_angle - {zero_offset_r, 3'h0};
            age_r <= '0;
            pipe_vld_r <= ready;
        end else if (age_r == ($clog2(RESP_CYCLES+1))'(RESP_CYCLES - apw_pkg::ANGLE_UPDATE_CYCLES)) begin
            age_r <= '0;
            pipe_vld_r <= 1'b0;
        end else begin
            age_r <= age_r + 1'b1;
        end
    end

    logic [14:0] aged_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aged_r <= 15'h0000;
        end else if (pipe_vld_r && age_r == '0) begin
            aged_r <= pipe_r;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            angle_r <= 15'h0000;
            inc_update <= 1'b0;
        end else begin
            inc_update <= 1'b0;
            if (upd_tick) begin
                angle_r <= aged_r;
                inc_update <= (aged_r != angle_r);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            angle_zcd_r <= 12'h000;
        end else if (zcd_tick) begin
            angle_zcd_r <= raw_zcd;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            field_r <= 12'h000;
        end else if (fld_tick) begin
            field_r <= raw_field;
        end
    end

    // Serial output. Capture on the first cycle chip select is seen low, well inside 125 ns.
    logic cs_n_d_r;
    logic [15:0] sh_r;
    logic [4:0] bit_cnt_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cs_n_d_r <= 1'b1;
            sh_r <= apw_pkg::SERIAL_OUT_RST;
            bit_cnt_r <= 5'h00;
            spi_miso <= 1'b0;
        end else begin
            cs_n_d_r <= spi_cs_n;
            if (cs_n_d_r && !spi_cs_n) begin
                // The cleared spi_miso is the dead bit; payload follows it, and a zero pads the low end.
                if (spi_sel_15b) begin
                    sh_r <= {angle_r, 1'b0};
                end else begin
                    sh_r <= {angle_r[14:3], err_flags[3:1], 1'b0};
                end
                bit_cnt_r <= 5'h00;
                spi_miso <= 1'b0;
            end else if (!spi_cs_n && spi_sclk_fall && bit_cnt_r != 5'h10) begin
                spi_miso <= sh_r[15];
                sh_r <= {sh_r[14:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // Carrier period in clocks, 128 settings; error style 1 doubles it (half frequency).
    logic mode_err_r;
    logic mode_tri_r;
    logic [12:0] high_r;
    logic [12:0] pcnt_r;
    logic [13:0] pcnt_sum;
    logic end_of_period;
    logic [17:0] base_per;
    logic [17:0] per_clk;
    logic [17:0] acc_r;
    logic [18:0] acc_sum;
    logic [18:0] acc_rem;
    logic [1:0] inc;
    assign base_per = 18'(apw_pkg::PWM_BASE_CYCLES)
        + (18'(apw_pkg::PWM_BAND_UNIT + apw_pkg::PWM_FINE_UNIT * int'(pwm_freq)) << pwm_band);
    assign per_clk = mode_err_r ? {base_per[16:0], 1'b0} : base_per;

    // Each clock adds a period's worth of ticks; the period never drops below 3200 clocks,
    // so at most two ticks fall in one clock and no division is needed.
    always_comb begin
        acc_sum = {1'b0, acc_r} + 19'(apw_pkg::PWM_PERIOD_TICKS);
        if (acc_sum >= {per_clk, 1'b0}) begin
            inc = 2'h2;
            acc_rem = acc_sum - {per_clk, 1'b0};
        end else if (acc_sum >= {1'b0, per_clk}) begin
            inc = 2'h1;
            acc_rem = acc_sum - {1'b0, per_clk};
        end else begin
            inc = 2'h0;
            acc_rem = acc_sum;
        end
    end
    assign pcnt_sum = {1'b0, pcnt_r} + 14'(inc);
    assign end_of_period = (pcnt_sum >= 14'(apw_pkg::PWM_PERIOD_TICKS));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc_r <= 18'h00000;
        end else begin
            acc_r <= acc_rem[17:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pcnt_r <= 13'h0000;
            mode_err_r <= 1'b0;
            mode_tri_r <= 1'b0;
            high_r <= 13'(apw_pkg::PWM_CLAMP_LO_TICKS);
        end else if (end_of_period) begin
            pcnt_r <= 13'(pcnt_sum - 14'(apw_pkg::PWM_PERIOD_TICKS));
            // New mode and duty only take effect at the boundary.
            mode_tri_r <= pwm_err_out_en && err_any && !pwm_err_style;
            mode_err_r <= pwm_err_out_en && err_any && pwm_err_style;
            if (pwm_err_out_en && err_any && pwm_err_style) begin
                high_r <= err_ticks;
            end else begin
                // 228 + angle12 gives 5% at 0x000 and 95% at 0xfff.
                high_r <= 13'(apw_pkg::PWM_CLAMP_LO_TICKS) + {1'b0, angle_r[14:3]};
            end
        end else begin
            pcnt_r <= pcnt_sum[12:0];
        end
    end

    // Rising edge always at count 0; falling at high_r, which is never 0 or full period.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwm_o <= 1'b0;
            pwm_oe <= 1'b0;
        end else begin
            pwm_o <= (pcnt_r < high_r);
            pwm_oe <= ready && !mode_tri_r;
        end
    end
endmodule

// ### testbench/angle_pwm_output_timing_tb_top.sv
`timescale 1ns/1ps
module angle_pwm_output_timing_tb_top;
    logic core_clk, rstn, pwm_err_out_en, pwm_err_style, spi_sel_15b, trim_wr, write_adr_wr;
    logic [14:0] raw_angle;
    logic [11:0] raw_zcd, raw_field, ee_zero_offset, err_vec, trim_wdata;
    logic [2:0] pwm_band;
    logic [3:0] pwm_freq, err_flags;
    logic [7:0] write_adr_wdata;
    logic spi_cs_n, spi_sclk_fall, pwm_o, pwm_oe, spi_miso, inc_update, ready;
    logic [14:0] angle_r;
    logic [11:0] angle_zcd_r, field_r, zero_offset_r;
    logic [7:0] write_adr_r;
    logic [15:0] w;
    int n_errors = 0;
    int check_count = 0;
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    apw_top #(.RESP_CYCLES(20)) dut (.core_clk(core_clk), .rstn(rstn), .raw_angle(raw_angle),
        .raw_zcd(raw_zcd), .raw_field(raw_field), .ee_zero_offset(ee_zero_offset),
        .pwm_band(pwm_band), .pwm_freq(pwm_freq), .pwm_err_out_en(pwm_err_out_en),
        .pwm_err_style(pwm_err_style), .err_vec(err_vec), .err_flags(err_flags),
        .spi_sel_15b(spi_sel_15b), .spi_cs_n(spi_cs_n), .spi_sclk_fall(spi_sclk_fall),
        .trim_wr(trim_wr), .trim_wdata(trim_wdata), .write_adr_wdata(write_adr_wdata),
        .write_adr_wr(write_adr_wr), .pwm_o(pwm_o), .pwm_oe(pwm_oe), .spi_miso(spi_miso),
        .angle_r(angle_r), .inc_update(inc_update), .angle_zcd_r(angle_zcd_r),
        .field_r(field_r), .zero_offset_r(zero_offset_r), .write_adr_r(write_adr_r),
        .ready(ready));
    apw_host host (.core_clk(core_clk), .pwm_o(pwm_o), .pwm_oe(pwm_oe), .spi_miso(spi_miso),
        .spi_cs_n(spi_cs_n), .spi_sclk_fall(spi_sclk_fall));
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Carrier steps are approximated, so timing is judged to within two percent plus two clocks.
    task automatic near(string name, int exp, int got);
        check_count++;
        if (got < exp - exp / 50 - 2 || got > exp + exp / 50 + 2) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    // The first period after a change may still be the old waveform, so it is skipped.
    task automatic pwm_chk(int ticks, int per);
        int hi, p;
        host.measure(hi, p);
        host.measure(hi, p);
        if (p < 0) begin
            n_errors++;
            stop_test();
        end
        near("period", per, p);
        near("high time", per * ticks / 4551, hi);
    endtask
    task automatic wr_adr(logic [7:0] d);
        @(posedge core_clk) write_adr_wr <= 1'b1;
        write_adr_wdata <= d;
        @(posedge core_clk) write_adr_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    initial begin
        {rstn, pwm_err_out_en, pwm_err_style, trim_wr, pwm_band, pwm_freq} = '0;
        {raw_angle, raw_zcd, raw_field, err_vec, trim_wdata} = '0;
        {spi_sel_15b, write_adr_wr, write_adr_wdata} = {1'b1, 1'b1, 8'h5a};
        {ee_zero_offset, err_flags} = {12'h123, 4'ha};
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk) write_adr_wr <= 1'b0;
        @(posedge core_clk);
        cmp("write_adr_r", 16'h0000, {8'h00, write_adr_r});
        cmp("zero_offset_r", 16'h0123, {4'h0, zero_offset_r});
        wr_adr(8'h3c);
        cmp("write_adr_r", 16'h003c, {8'h00, write_adr_r});
        @(posedge core_clk) trim_wr <= 1'b1;
        @(posedge core_clk) trim_wr <= 1'b0;
        @(posedge core_clk) raw_angle <= 15'h5a5b;
        cmp("zero_offset_r", 16'h0000, {4'h0, zero_offset_r});
        repeat (60) @(posedge core_clk);
        cmp("angle_r", 16'h5a5b, {1'b0, angle_r});
        host.spi_read(w);
        cmp("spi 15-bit", 16'h5a5b, w);
        spi_sel_15b <= 1'b0;
        fork
            host.spi_read(w);
            begin
                repeat (5) @(posedge core_clk);
                raw_angle <= 15'h0000;
            end
        join
        cmp("spi 12-bit", {1'b0, 12'hb4b, 3'h5}, w);
        raw_zcd <= 12'h3a7;
        raw_field <= 12'h6c1;
        pwm_chk(228, 3200);
        raw_angle <= 15'h7fff;
        pwm_chk(4323, 3200);
        err_vec <= 12'hfff;
        pwm_chk(4323, 3200);
        cmp("zcd", 16'h03a7, {4'h0, angle_zcd_r});
        cmp("field", 16'h06c1, {4'h0, field_r});
        pwm_err_out_en <= 1'b1;
        repeat (6500) @(posedge core_clk);
        cmp("pwm_oe", 16'h0000, {15'h0000, pwm_oe});
        pwm_err_style <= 1'b1;
        pwm_chk(228, 6400);
        err_vec <= 12'h800;
        pwm_chk(3043, 6400);
        {err_vec, pwm_band} <= {12'h000, 3'h3};
        pwm_chk(4323, 6000);
        stop_test();
    end
endmodule

// ### testbench/apw_host.sv
`timescale 1ns/1ps
module apw_host (
    input wire logic core_clk,
    input wire logic pwm_o,
    input wire logic pwm_oe,
    input wire logic spi_miso,
    output logic spi_cs_n,
    output logic spi_sclk_fall
);
    // No pull is fitted, so a released pin floats and reads as z.
    wire pin = pwm_oe ? pwm_o : 1'bz;
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk_fall = 1'b0;
    end
    // Each bit is taken before the shift pulse that advances to the next one.
    task automatic spi_read(output logic [15:0] w);
        @(posedge core_clk) spi_cs_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            w[i] = spi_miso;
            spi_sclk_fall <= 1'b1;
            @(posedge core_clk) spi_sclk_fall <= 1'b0;
            @(posedge core_clk);
        end
        spi_cs_n <= 1'b1;
    endtask
    task automatic measure(output int hi, output int per);
        int n;
        n = 0;
        hi = 0;
        per = 0;
        while (pin !== 1'b0 && n < 20000) begin @(posedge core_clk); n++; end
        while (pin !== 1'b1 && n < 20000) begin @(posedge core_clk); n++; end
        while (pin === 1'b1 && n < 20000) begin @(posedge core_clk); n++; hi++; end
        while (pin === 1'b0 && n < 20000) begin @(posedge core_clk); n++; per++; end
        per = (n >= 20000) ? -1 : per + hi;
    endtask
endmodule

// ### testbench/apw_top_asserts.sv
`timescale 1ns/1ps
module apw_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [11:0] ee_zero_offset,
    input wire logic pwm_err_out_en,
    input wire logic pwm_err_style,
    input wire logic [11:0] err_vec,
    input wire logic spi_cs_n,
    input wire logic spi_sclk_fall,
    input wire logic trim_wr,
    input wire logic [11:0] trim_wdata,
    input wire logic [7:0] write_adr_wdata,
    input wire logic write_adr_wr,
    input wire logic pwm_oe,
    input wire logic spi_miso,
    input wire logic [14:0] angle_r,
    input wire logic inc_update,
    input wire logic [11:0] zero_offset_r,
    input wire logic [7:0] write_adr_r,
    input wire logic ready
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    pin_release_a:
        assert property ($fell(pwm_oe) |-> $past(pwm_err_out_en && !pwm_err_style && (|err_vec)))
        else $error("pwm pin released without tristate error");
    dead_bit_a:
        assert property ($fell(spi_cs_n) |=> !spi_miso)
        else $error("first serial bit not zero");
    word_hold_a:
        assert property ($changed(spi_miso) |-> $past(spi_sclk_fall) || $past(spi_cs_n)
            || $past(spi_cs_n, 2))
        else $error("serial data moved without a shift");
    angle_rate_a:
        assert property ($changed(angle_r) |=> $stable(angle_r)[*8])
        else $error("angle register updated too often");
    inc_rate_a:
        assert property (inc_update |=> !inc_update[*8])
        else $error("incremental update pulsed too often");
    adr_refuse_a:
        assert property (!ready && write_adr_wr |=> write_adr_r == $past(write_adr_r))
        else $error("write pointer written before ready");
    adr_write_a:
        assert property (ready && write_adr_wr |=> write_adr_r == $past(write_adr_wdata))
        else $error("write pointer write lost");
    origin_load_a:
        assert property ($rose(ready) |-> zero_offset_r == $past(ee_zero_offset))
        else $error("origin trim not loaded from storage");
    trim_write_a:
        assert property (ready && trim_wr |=> zero_offset_r == $past(trim_wdata))
        else $error("trim write lost");
endmodule
bind apw_top apw_chk u_chk (.core_clk(core_clk), .rstn(rstn), .ee_zero_offset(ee_zero_offset),
    .pwm_err_out_en(pwm_err_out_en), .pwm_err_style(pwm_err_style), .err_vec(err_vec),
    .spi_cs_n(spi_cs_n), .spi_sclk_fall(spi_sclk_fall), .trim_wr(trim_wr),
    .trim_wdata(trim_wdata), .write_adr_wdata(write_adr_wdata), .write_adr_wr(write_adr_wr),
    .pwm_oe(pwm_oe), .spi_miso(spi_miso), .angle_r(angle_r), .inc_update(inc_update),
    .zero_offset_r(zero_offset_r), .write_adr_r(write_adr_r), .ready(ready));
